// ===== ssq_pkg.sv
// Constants, types and register map of the supply state sequencer
package ssq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (16-bit register numbers of the serial protocol)
	localparam logic [15:0] ADDR_WARN_FLAGS = 16'h9cc3;
	localparam logic [15:0] ADDR_FAULT_CLEAR = 16'h9cce;
	localparam logic [15:0] ADDR_OP_CMD = 16'h9ccf;
	localparam logic [15:0] ADDR_CUR_WARN_LVL = 16'h9d00;
	localparam logic [15:0] ADDR_CUR_WARN_HYST = 16'h9d01;
	localparam logic [15:0] ADDR_LINE_WARN_LVL = 16'h9d03;
	localparam logic [15:0] ADDR_LINE_WARN_HYST = 16'h9d04;
	localparam logic [15:0] ADDR_OUT_WARN_LVL = 16'h9d06;
	localparam logic [15:0] ADDR_OUT_WARN_HYST = 16'h9d07;
	localparam logic [15:0] ADDR_RESUME_DELAY = 16'h9d39;
	localparam logic [15:0] ADDR_RETRY_LIMIT = 16'h9d3a;
	localparam logic [15:0] ADDR_RETRY_WINDOW = 16'h9d3b;
	localparam logic [15:0] ADDR_OFFLINE_LIMIT = 16'h9d3c;

	////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [15:0] OP_CONNECT = 16'h0001;
	localparam logic [15:0] OP_DISCONNECT = 16'h0002;
	localparam logic [15:0] OP_STANDBY = 16'h0003;
	localparam logic [15:0] OP_RUN = 16'h0004;
	localparam logic [15:0] FAULT_CLEAR_CODE = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// Reset values; times count in 100 ms ticks
	localparam logic [15:0] RST_RETRY_LIMIT = 16'h0002;
	localparam logic [15:0] RST_RETRY_WINDOW = 16'h0032;
	localparam logic [15:0] RST_RESUME_DELAY = 16'h0032;
	localparam logic [15:0] RST_OFFLINE_LIMIT = 16'h0000;
	localparam logic [15:0] RST_WARN_LVL = 16'hffff;
	localparam logic [15:0] RST_WARN_HYST = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Warning bit positions
	localparam int WB_CUR_A = 0;
	localparam int WB_LINE_AB = 3;
	localparam int WB_OUT_V = 6;
	localparam int WB_PLL = 7;
	localparam int WB_CUR_LIM = 8;
	localparam int WB_PWR_LIM = 9;
	localparam int WB_RETRY_DLY = 10;

	// Fault latch bit positions
	localparam int FB_EXT = 0;
	localparam int FB_ESTOP = 1;
	localparam int FB_LINE_LOSS = 2;
	localparam int FB_MAX_RETRY = 3;
	localparam int FB_TIMEOUT = 4;
	localparam int FAULT_W = 5;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam logic [4:0] HOUSEKEEP_CYCLES = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		ST_INIT, ST_CAL, ST_DISABLED, ST_CHG_WAIT, ST_CHARGING,
		ST_STANDBY, ST_RUNNING, ST_OFFLINE, ST_FAULT, ST_SHUTDOWN
	} ssq_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ssq_reg_req_s;

	typedef struct packed {
		logic [15:0] i_a;
		logic [15:0] i_b;
		logic [15:0] i_c;
		logic [15:0] v_ab;
		logic [15:0] v_bc;
		logic [15:0] v_ca;
		logic [15:0] v_out;
	} ssq_meas_s;

endpackage

// ===== ssq_sequencer.sv
// Operating-state sequencer with retry supervision and warning flags
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire ssq_reg_req_s reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic bias_on_in,
	input wire logic estop_active_in,
	input wire logic init_ok_in,
	input wire logic cal_ok_in,
	input wire logic line_valid_in,
	input wire logic line_recover_in,
	input wire logic link_charged_in,
	input wire logic fault_detect_in,
	input wire logic pll_locked_in,
	input wire logic cur_limit_in,
	input wire logic pwr_limit_in,
	input wire ssq_meas_s meas_in,
	output ssq_state_e state_out,
	output logic precharge_en,
	output logic contactor_close,
	output logic power_stage_on,
	output logic bias_supply_en,
	output logic fault_active,
	output logic [FAULT_W-1:0] fault_flags,
	output logic [15:0] warning_flags,
	output logic warning_any
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Hysteretic flag: set above level, clear below level minus delta
	function automatic logic hyst_flag(input logic flag,
		input logic [15:0] val, input logic [15:0] lvl,
		input logic [15:0] hyst);
		logic [15:0] low;
		low = (hyst > lvl) ? 16'h0000 : lvl - hyst;
		if (val > lvl) begin
			return 1'b1;
		end else if (val < low) begin
			return 1'b0;
		end
		return flag;
	endfunction

	function automatic logic addr_hit(input ssq_reg_req_s r,
		input logic [15:0] a);
		return r.wr && (r.addr == a);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; first stage read only by the second
	logic [10:0] pin_s1_q, pin_s2_q;
	ssq_meas_s meas_s1_q, meas_s2_q;
	always_ff @(posedge clk_sys) begin
		pin_s1_q <= {bias_on_in, estop_active_in, init_ok_in, cal_ok_in,
			line_valid_in, line_recover_in, link_charged_in,
			fault_detect_in, pll_locked_in, cur_limit_in, pwr_limit_in};
		pin_s2_q <= pin_s1_q;
		meas_s1_q <= meas_in;
		meas_s2_q <= meas_s1_q;
	end

	wire bias_on = pin_s2_q[10];
	wire estop = pin_s2_q[9];
	wire init_ok = pin_s2_q[8];
	wire cal_ok = pin_s2_q[7];
	wire line_ok = pin_s2_q[6];
	wire line_rec = pin_s2_q[5];
	wire link_ok = pin_s2_q[4];
	wire fault_det = pin_s2_q[3];
	wire pll_lock = pin_s2_q[2];
	wire cur_lim = pin_s2_q[1];
	wire pwr_lim = pin_s2_q[0];

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [15:0] fault_clear_q, op_cmd_q;
	logic [15:0] cur_lvl_q, cur_hyst_q, line_lvl_q, line_hyst_q;
	logic [15:0] out_lvl_q, out_hyst_q;
	logic [15:0] resume_dly_q, retry_lim_q, retry_win_q, off_lim_q;
	logic [15:0] warn_q, rdata_d;

	wire cmd_wr = addr_hit(reg_req, ADDR_OP_CMD);
	wire clr_wr = addr_hit(reg_req, ADDR_FAULT_CLEAR) &&
		(reg_req.wdata == FAULT_CLEAR_CODE);
	wire cmd_connect = cmd_wr && (reg_req.wdata == OP_CONNECT);
	wire cmd_disc = cmd_wr && (reg_req.wdata == OP_DISCONNECT);
	wire cmd_stby = cmd_wr && (reg_req.wdata == OP_STANDBY);
	wire cmd_run = cmd_wr && (reg_req.wdata == OP_RUN);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fault_clear_q <= 16'h0000;
			op_cmd_q <= 16'h0000;
			cur_lvl_q <= RST_WARN_LVL;
			cur_hyst_q <= RST_WARN_HYST;
			line_lvl_q <= RST_WARN_LVL;
			line_hyst_q <= RST_WARN_HYST;
			out_lvl_q <= RST_WARN_LVL;
			out_hyst_q <= RST_WARN_HYST;
			resume_dly_q <= RST_RESUME_DELAY;
			retry_lim_q <= RST_RETRY_LIMIT;
			retry_win_q <= RST_RETRY_WINDOW;
			off_lim_q <= RST_OFFLINE_LIMIT;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				ADDR_FAULT_CLEAR: fault_clear_q <= reg_req.wdata;
				ADDR_OP_CMD: op_cmd_q <= reg_req.wdata;
				ADDR_CUR_WARN_LVL: cur_lvl_q <= reg_req.wdata;
				ADDR_CUR_WARN_HYST: cur_hyst_q <= reg_req.wdata;
				ADDR_LINE_WARN_LVL: line_lvl_q <= reg_req.wdata;
				ADDR_LINE_WARN_HYST: line_hyst_q <= reg_req.wdata;
				ADDR_OUT_WARN_LVL: out_lvl_q <= reg_req.wdata;
				ADDR_OUT_WARN_HYST: out_hyst_q <= reg_req.wdata;
				ADDR_RESUME_DELAY: resume_dly_q <= reg_req.wdata;
				ADDR_RETRY_LIMIT: retry_lim_q <= reg_req.wdata;
				ADDR_RETRY_WINDOW: retry_win_q <= reg_req.wdata;
				ADDR_OFFLINE_LIMIT: off_lim_q <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// Unmapped addresses read as zero; the command registers read back the last value written
	always_comb begin
		case (reg_req.addr)
			ADDR_WARN_FLAGS: rdata_d = warn_q;
			ADDR_FAULT_CLEAR: rdata_d = fault_clear_q;
			ADDR_OP_CMD: rdata_d = op_cmd_q;
			ADDR_CUR_WARN_LVL: rdata_d = cur_lvl_q;
			ADDR_CUR_WARN_HYST: rdata_d = cur_hyst_q;
			ADDR_LINE_WARN_LVL: rdata_d = line_lvl_q;
			ADDR_LINE_WARN_HYST: rdata_d = line_hyst_q;
			ADDR_OUT_WARN_LVL: rdata_d = out_lvl_q;
			ADDR_OUT_WARN_HYST: rdata_d = out_hyst_q;
			ADDR_RESUME_DELAY: rdata_d = resume_dly_q;
			ADDR_RETRY_LIMIT: rdata_d = retry_lim_q;
			ADDR_RETRY_WINDOW: rdata_d = retry_win_q;
			ADDR_OFFLINE_LIMIT: rdata_d = off_lim_q;
			default: rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_req.rd ? rdata_d : 16'h0000;
			reg_rvalid <= reg_req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 100 ms time base
	logic [31:0] tick_cnt_q;
	wire tick = (tick_cnt_q == 32'(TICK_CYCLES_P - 1));
	always_ff @(posedge clk_sys) begin
		if (sys_rst || tick) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offline supervision
	ssq_state_e state_q, state_d;
	logic [15:0] resume_cnt_q, off_cnt_q, win_cnt_q, retry_cnt_q;
	logic auto_run_q, cal_done_q;
	logic [4:0] hk_cnt_q;
	logic [FAULT_W-1:0] fault_q, fault_set, fault_d;

	wire offline = (state_q == ST_OFFLINE);
	wire autoresume_en = (retry_lim_q != 16'h0000);
	// Act only on a tick unless the resume delay is zero: the tick phase is unrelated to state entry
	wire resume_due = offline && line_rec &&
		(resume_cnt_q >= resume_dly_q) &&
		(tick || resume_dly_q == 16'h0000);
	wire [15:0] retry_next = (win_cnt_q != 16'h0000) ?
		retry_cnt_q + 16'h0001 : 16'h0001;
	wire retry_over = resume_due && (retry_next > retry_lim_q);
	wire off_timeout = offline && (off_lim_q != 16'h0000) && tick &&
		(off_cnt_q >= off_lim_q);
	wire line_loss = (state_q == ST_RUNNING) && !line_ok;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			resume_cnt_q <= 16'h0000;
			off_cnt_q <= 16'h0000;
			win_cnt_q <= 16'h0000;
			retry_cnt_q <= 16'h0000;
		end else begin
			// Delay restarts whenever the line drops out again
			if (!offline || !line_rec) begin
				resume_cnt_q <= 16'h0000;
			end else if (tick && !resume_due) begin
				resume_cnt_q <= resume_cnt_q + 16'h0001;
			end
			if (!offline) begin
				off_cnt_q <= 16'h0000;
			end else if (tick && !off_timeout) begin
				off_cnt_q <= off_cnt_q + 16'h0001;
			end
			if (resume_due) begin
				win_cnt_q <= retry_win_q;
				retry_cnt_q <= retry_next;
			end else if (tick && win_cnt_q != 16'h0000) begin
				win_cnt_q <= win_cnt_q - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault latches; a set in the clear cycle wins
	always_comb begin
		fault_set = '0;
		if (state_q != ST_SHUTDOWN) begin
			fault_set[FB_EXT] = fault_det;
			fault_set[FB_ESTOP] = estop;
			fault_set[FB_LINE_LOSS] = line_loss && !autoresume_en;
			fault_set[FB_MAX_RETRY] = retry_over;
			fault_set[FB_TIMEOUT] = off_timeout;
		end
		fault_d = (clr_wr ? '0 : fault_q) | fault_set;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fault_q <= '0;
		end else begin
			fault_q <= fault_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_INIT: if (init_ok) state_d = ST_CAL;
			ST_CAL: if (cal_ok) state_d = ST_DISABLED;
			ST_DISABLED: begin
				if (!bias_on) begin
					state_d = ST_SHUTDOWN;
				end else if (cmd_connect && !estop) begin
					state_d = line_ok ? ST_CHARGING : ST_CHG_WAIT;
				end
			end
			ST_CHG_WAIT: begin
				if (cmd_disc) begin
					state_d = ST_DISABLED;
				end else if (line_rec) begin
					state_d = ST_CHARGING;
				end
			end
			ST_CHARGING: begin
				if (cmd_disc) begin
					state_d = ST_DISABLED;
				end else if (link_ok) begin
					state_d = auto_run_q ? ST_RUNNING : ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (cmd_run) begin
					state_d = ST_RUNNING;
				end else if (cmd_disc) begin
					state_d = ST_DISABLED;
				end
			end
			ST_RUNNING: begin
				if (!line_ok) begin
					state_d = ST_OFFLINE;
				end else if (cmd_stby) begin
					state_d = ST_STANDBY;
				end else if (cmd_disc) begin
					state_d = ST_DISABLED;
				end
			end
			ST_OFFLINE: begin
				if (cmd_disc) begin
					state_d = ST_DISABLED;
				end else if (cmd_stby) begin
					state_d = ST_CHG_WAIT;
				end else if (resume_due) begin
					state_d = ST_CHARGING;
				end
			end
			ST_FAULT: begin
				if (!bias_on) begin
					state_d = ST_SHUTDOWN;
				end else if (clr_wr && fault_d == '0) begin
					state_d = cal_done_q ? ST_DISABLED : ST_CAL;
				end
			end
			ST_SHUTDOWN: state_d = ST_SHUTDOWN;
			default: state_d = ST_INIT;
		endcase
		// Any latch event overrides, except a shutdown already chosen:
		// a persisting fault must not keep the bias up
		if (fault_set != '0 && state_d != ST_SHUTDOWN) begin
			state_d = ST_FAULT;
		end else if (!bias_on && state_q != ST_FAULT &&
			state_q != ST_DISABLED && state_q != ST_SHUTDOWN) begin
			state_d = ST_DISABLED;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= ST_INIT;
			auto_run_q <= 1'b0;
			cal_done_q <= 1'b0;
			hk_cnt_q <= 5'h00;
		end else begin
			state_q <= state_d;
			if (state_q == ST_CAL && state_d == ST_DISABLED) begin
				cal_done_q <= 1'b1;
			end
			// Only a timed resume skips standby
			if (state_q == ST_OFFLINE && state_d == ST_CHARGING) begin
				auto_run_q <= 1'b1;
			end else if (state_d != ST_CHARGING) begin
				auto_run_q <= 1'b0;
			end
			if (state_q == ST_SHUTDOWN && hk_cnt_q != HOUSEKEEP_CYCLES) begin
				hk_cnt_q <= hk_cnt_q + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Warnings; never feed the state machine
	logic [15:0] warn_d;
	always_comb begin
		warn_d = 16'h0000;
		warn_d[WB_CUR_A] = hyst_flag(warn_q[WB_CUR_A], meas_s2_q.i_a,
			cur_lvl_q, cur_hyst_q);
		warn_d[WB_CUR_A+1] = hyst_flag(warn_q[WB_CUR_A+1], meas_s2_q.i_b,
			cur_lvl_q, cur_hyst_q);
		warn_d[WB_CUR_A+2] = hyst_flag(warn_q[WB_CUR_A+2], meas_s2_q.i_c,
			cur_lvl_q, cur_hyst_q);
		warn_d[WB_LINE_AB] = hyst_flag(warn_q[WB_LINE_AB], meas_s2_q.v_ab,
			line_lvl_q, line_hyst_q);
		warn_d[WB_LINE_AB+1] = hyst_flag(warn_q[WB_LINE_AB+1],
			meas_s2_q.v_bc, line_lvl_q, line_hyst_q);
		warn_d[WB_LINE_AB+2] = hyst_flag(warn_q[WB_LINE_AB+2],
			meas_s2_q.v_ca, line_lvl_q, line_hyst_q);
		warn_d[WB_OUT_V] = hyst_flag(warn_q[WB_OUT_V], meas_s2_q.v_out,
			out_lvl_q, out_hyst_q);
		warn_d[WB_PLL] = !pll_lock;
		warn_d[WB_CUR_LIM] = cur_lim;
		warn_d[WB_PWR_LIM] = pwr_lim;
		warn_d[WB_RETRY_DLY] = offline && line_rec && !resume_due;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			warn_q <= 16'h0000;
			warning_any <= 1'b0;
		end else begin
			warn_q <= warn_d;
			warning_any <= (warn_d != 16'h0000);
		end
	end
	assign warning_flags = warn_q;

	////////////////////////////////////////////////////////////////////////
	// Registered power-stage outputs follow the next state; bias enable follows the current state and housekeeping count
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			precharge_en <= 1'b0;
			contactor_close <= 1'b0;
			power_stage_on <= 1'b0;
			bias_supply_en <= 1'b1;
			fault_active <= 1'b0;
			fault_flags <= '0;
		end else begin
			precharge_en <= (state_d == ST_CHARGING);
			contactor_close <= (state_d == ST_STANDBY) ||
				(state_d == ST_RUNNING);
			power_stage_on <= (state_d == ST_RUNNING);
			bias_supply_en <= !(state_q == ST_SHUTDOWN &&
				hk_cnt_q == HOUSEKEEP_CYCLES);
			fault_active <= (fault_d != '0);
			fault_flags <= fault_d;
		end
	end
	assign state_out = state_q;

endmodule

// ===== ssq_monitor.sv
// Port checker of the supply state sequencer
module ssq_monitor
	import ssq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire ssq_reg_req_s reg_req,
	input wire logic [15:0] reg_rdata,
	input wire ssq_state_e state_out,
	input wire logic precharge_en,
	input wire logic contactor_close,
	input wire logic power_stage_on,
	input wire logic bias_supply_en,
	input wire logic fault_active,
	input wire logic [15:0] warning_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	wire run_wr = reg_req.wr && reg_req.addr == ADDR_OP_CMD &&
		reg_req.wdata == OP_RUN;
	wire clr_wr = reg_req.wr && reg_req.addr == ADDR_FAULT_CLEAR;

	AST_FAULT_OFF:
	assert property (state_out == ST_FAULT |-> !power_stage_on &&
		!contactor_close) else $error("power on while in fault");
	AST_PWR_RUN:
	assert property (power_stage_on |-> state_out == ST_RUNNING)
		else $error("power stage on outside running");
	AST_DIS_OPEN:
	assert property (state_out == ST_DISABLED |-> !contactor_close &&
		!precharge_en) else $error("disabled with contactor closed");
	AST_PRECHG:
	assert property (precharge_en == (state_out == ST_CHARGING))
		else $error("pre-charge out of charging");
	AST_RUN_CMD:
	assert property (state_out == ST_STANDBY && run_wr && !fault_active
		|=> state_out == ST_RUNNING) else $error("run ignored");
	AST_WARN_RD:
	assert property (reg_req.rd && reg_req.addr == ADDR_WARN_FLAGS
		|=> reg_rdata == $past(warning_flags)) else $error("warn read");
	AST_FAULT_IN:
	assert property (fault_active && !clr_wr && state_out != ST_SHUTDOWN
		|=> state_out == ST_FAULT) else $error("fault not entered");
	AST_BIAS_OFF:
	assert property ($fell(bias_supply_en) |-> $past(state_out, 8) ==
		ST_SHUTDOWN) else $error("bias dropped without housekeeping");
endmodule

bind ssq_sequencer ssq_monitor mon_u (.clk_sys, .sys_rst, .reg_req,
	.reg_rdata, .state_out, .precharge_en, .contactor_close,
	.power_stage_on, .bias_supply_en, .fault_active, .warning_flags);

// ===== ssq_host.sv
// Behavioural system controller issuing register requests
module ssq_host
	import ssq_pkg::*;
(
	input wire logic clk_sys,
	output ssq_reg_req_s reg_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial reg_req = '0;

	// Idle address and data scrambled so a stale value is never trusted
	task automatic idle();
		reg_req <= '{1'b0, 1'b0, 16'($urandom), 16'($urandom)};
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		idle();
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b1, a, 16'($urandom)};
		@(posedge clk_sys);
		idle();
	endtask

	// Gap lets each step settle; a run sent before standby is dropped
	task automatic restore(input int gap);
		wr(ADDR_FAULT_CLEAR, FAULT_CLEAR_CODE);
		repeat (gap) @(posedge clk_sys);
		wr(ADDR_OP_CMD, OP_CONNECT);
		repeat (gap) @(posedge clk_sys);
		wr(ADDR_OP_CMD, OP_RUN);
	endtask
endmodule

// ===== tb_top.sv
// Self-checking bench of the supply state sequencer
module tb_top
	import ssq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	localparam logic [15:0] WL[3] = '{ADDR_CUR_WARN_LVL, ADDR_LINE_WARN_LVL,
		ADDR_OUT_WARN_LVL};
	localparam int WBIT[3] = '{WB_CUR_A, WB_LINE_AB, WB_OUT_V};
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	ssq_reg_req_s reg_req;
	logic [15:0] reg_rdata, warning_flags;
	logic reg_rvalid, precharge_en, contactor_close, power_stage_on;
	logic bias_supply_en, fault_active, warning_any;
	logic bias_on_in = 1'b1, estop_active_in = 1'b0, init_ok_in = 1'b0;
	logic cal_ok_in = 1'b0, line_valid_in = 1'b1, line_recover_in = 1'b1;
	logic link_charged_in = 1'b1, fault_detect_in = 1'b0;
	logic pll_locked_in = 1'b1, cur_limit_in = 1'b0, pwr_limit_in = 1'b0;
	ssq_meas_s meas_in = '0;
	ssq_state_e state_out;
	logic [FAULT_W-1:0] fault_flags;
	logic [15:0] exp_q[$];
	int n_mismatch = 0;
	int n_checks = 0;

	initial forever #10 clk_sys = ~clk_sys;

	ssq_sequencer #(.TICK_CYCLES_P(TK)) dut_u (.clk_sys, .sys_rst, .reg_req,
		.reg_rdata, .reg_rvalid, .bias_on_in, .estop_active_in, .init_ok_in,
		.cal_ok_in, .line_valid_in, .line_recover_in, .link_charged_in,
		.fault_detect_in, .pll_locked_in, .cur_limit_in, .pwr_limit_in,
		.meas_in, .state_out, .precharge_en, .contactor_close,
		.power_stage_on, .bias_supply_en, .fault_active, .fault_flags,
		.warning_flags, .warning_any);
	ssq_host host_u (.clk_sys, .reg_req);

	////////////////////////////////////////////////////////////////////////
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
		chk_val(got, exp, "read data");
	endtask

	// Each answer is matched with the oldest outstanding read
	always @(posedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			chk_rd(reg_rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
		end
	end

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.rd(a);
	endtask

	task automatic wst(input ssq_state_e s, input int n);
		for (int i = 0; i < n && state_out !== s; i++) @(posedge clk_sys);
		chk_val(16'(state_out), 16'(s), "state");
	endtask

	task automatic line(input logic v);
		@(posedge clk_sys);
		line_valid_in <= v;
		line_recover_in <= v;
	endtask

	task automatic clr();
		host_u.wr(ADDR_FAULT_CLEAR, FAULT_CLEAR_CODE);
	endtask

	task automatic go_run();
		host_u.wr(ADDR_OP_CMD, OP_CONNECT);
		wst(ST_STANDBY, 20);
		host_u.wr(ADDR_OP_CMD, OP_RUN);
		wst(ST_RUNNING, 5);
	endtask

	task automatic set_m(input int k, input logic [15:0] v);
		@(posedge clk_sys);
		case (k)
			0: meas_in.i_a <= v;
			1: meas_in.v_ab <= v;
			default: meas_in.v_out <= v;
		endcase
		repeat (5) @(posedge clk_sys);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk_sys);
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] lv, hy;
		void'($urandom(30968));
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		wst(ST_INIT, 0);
		rd(ADDR_RETRY_LIMIT, 16'h0002);
		rd(ADDR_RETRY_WINDOW, 16'h0032);
		rd(ADDR_OFFLINE_LIMIT, 16'h0000);
		rd(16'h1234, 16'h0000);
		host_u.wr(ADDR_OP_CMD, OP_RUN);
		repeat (4) @(posedge clk_sys);
		wst(ST_INIT, 0);
		init_ok_in <= 1'b1;
		wst(ST_CAL, 10);
		cal_ok_in <= 1'b1;
		wst(ST_DISABLED, 10);
		line(1'b0);
		repeat (4) @(posedge clk_sys);
		host_u.wr(ADDR_OP_CMD, OP_CONNECT);
		wst(ST_CHG_WAIT, 5);
		line(1'b1);
		wst(ST_CHARGING, 10);
		wst(ST_STANDBY, 10);
		host_u.wr(ADDR_OP_CMD, OP_RUN);
		wst(ST_RUNNING, 5);
		chk_val(16'(power_stage_on & contactor_close), 16'h0001, "on");
		host_u.wr(ADDR_OP_CMD, OP_STANDBY);
		wst(ST_STANDBY, 5);
		host_u.wr(ADDR_OP_CMD, OP_RUN);
		wst(ST_RUNNING, 5);
		host_u.wr(ADDR_OP_CMD, OP_DISCONNECT);
		wst(ST_DISABLED, 5);
		// Two retries well inside a 20-tick window against a limit of one
		host_u.wr(ADDR_RETRY_LIMIT, 16'h0001);
		host_u.wr(ADDR_RETRY_WINDOW, 16'h0014);
		host_u.wr(ADDR_RESUME_DELAY, 16'h0001);
		go_run();
		for (int k = 0; k < 2; k++) begin
			line(1'b0);
			wst(ST_OFFLINE, 8);
			chk_val(16'(contactor_close), 16'h0000, "offline");
			line(1'b1);
			if (k == 0) begin
				wst(ST_RUNNING, 3 * TK + 20);
			end else begin
				wst(ST_FAULT, 3 * TK + 20);
			end
		end
		chk_val(16'(fault_flags), 16'h0008, "max retry");
		clr();
		wst(ST_DISABLED, 5);
		host_u.wr(ADDR_RETRY_LIMIT, 16'h0000);
		go_run();
		line(1'b0);
		wst(ST_FAULT, 8);
		chk_val(16'(fault_flags), 16'h0004, "line loss");
		line(1'b1);
		repeat (4) @(posedge clk_sys);
		host_u.restore(20);
		wst(ST_RUNNING, 20);
		host_u.wr(ADDR_RETRY_LIMIT, 16'h0002);
		host_u.wr(ADDR_RESUME_DELAY, 16'h00ff);
		host_u.wr(ADDR_OFFLINE_LIMIT, 16'h0002);
		line(1'b0);
		wst(ST_OFFLINE, 8);
		host_u.wr(ADDR_OP_CMD, OP_STANDBY);
		wst(ST_CHG_WAIT, 5);
		line(1'b1);
		wst(ST_STANDBY, 20);
		host_u.wr(ADDR_OP_CMD, OP_RUN);
		wst(ST_RUNNING, 5);
		line(1'b0);
		wst(ST_OFFLINE, 8);
		repeat (TK / 2) @(posedge clk_sys);
		wst(ST_OFFLINE, 0);
		wst(ST_FAULT, 3 * TK);
		chk_val(16'(fault_flags), 16'h0010, "timeout");
		line(1'b1);
		host_u.wr(ADDR_OFFLINE_LIMIT, 16'h0000);
		clr();
		wst(ST_DISABLED, 5);
		fault_detect_in <= 1'b1;
		wst(ST_FAULT, 8);
		host_u.wr(ADDR_OP_CMD, OP_CONNECT);
		clr();
		repeat (4) @(posedge clk_sys);
		wst(ST_FAULT, 0);
		chk_val(16'(fault_flags), 16'h0001, "persist");
		fault_detect_in <= 1'b0;
		repeat (4) @(posedge clk_sys);
		clr();
		wst(ST_DISABLED, 5);
		estop_active_in <= 1'b1;
		host_u.wr(ADDR_OP_CMD, OP_CONNECT);
		wst(ST_FAULT, 8);
		chk_val(16'(fault_flags), 16'h0002, "estop");
		chk_val(16'(fault_active), 16'h0001, "fault out");
		estop_active_in <= 1'b0;
		repeat (4) @(posedge clk_sys);
		clr();
		wst(ST_DISABLED, 5);
		chk_val(16'(fault_active), 16'h0000, "fault out");
		for (int k = 0; k < 3; k++) begin
			lv = 16'($urandom_range(1000, 2000));
			hy = 16'($urandom_range(10, 100));
			host_u.wr(WL[k], lv);
			host_u.wr(WL[k] + 16'h0001, hy);
			set_m(k, lv + 16'($urandom_range(1, 500)));
			rd(ADDR_WARN_FLAGS, 16'h0001 << WBIT[k]);
			set_m(k, lv - hy);
			rd(ADDR_WARN_FLAGS, 16'h0001 << WBIT[k]);
			set_m(k, lv - hy - 16'h0001);
			rd(ADDR_WARN_FLAGS, 16'h0000);
		end
		for (int j = 0; j < 3; j++) begin
			{pwr_limit_in, cur_limit_in, pll_locked_in} <= 3'h1 ^ (3'h1 << j);
			repeat (5) @(posedge clk_sys);
			rd(ADDR_WARN_FLAGS, 16'h0001 << (WB_PLL + j));
			chk_val(16'(warning_any), 16'h0001, "any");
			{pwr_limit_in, cur_limit_in, pll_locked_in} <= 3'h1;
			repeat (5) @(posedge clk_sys);
			rd(ADDR_WARN_FLAGS, 16'h0000);
			chk_val(16'(warning_any), 16'h0000, "any");
		end
		host_u.wr(ADDR_WARN_FLAGS, 16'hffff);
		rd(ADDR_WARN_FLAGS, 16'h0000);
		go_run();
		bias_on_in <= 1'b0;
		wst(ST_DISABLED, 10);
		wst(ST_SHUTDOWN, 5);
		for (int i = 0; i < 40 && bias_supply_en !== 1'b0; i++) begin
			@(posedge clk_sys);
		end
		chk_val(16'(bias_supply_en), 16'h0000, "bias");
		repeat (2) @(posedge clk_sys);
		stop_test();
	end
endmodule
